/* File: verilog/spin_knob_speed_encoder.v */
/*
 * Spin knob speed encoder: gates edge pulses into a saturating speed count,
 * raises a strobe when the gate ends and returns the count to the scanning
 * controller as one of sixteen key codes on its return lines.
 * Assumes scan lines come from the scanning controller asynchronously,
 * the knob square waves are asynchronous as well, and the system clock
 * runs at 40 MHz so that the gate and strobe counts in the defines header
 * give about 100 ms and 20 ms. The speed count is kept after the strobe so
 * the controller may scan it at leisure; it changes only when a new gate
 * opens.
 */
`timescale 1ns/100ps
`include "spin_knob_defines.vh"

module spin_knob_speed_encoder (
    input wire SYS_CLK,
    input wire RESET_N,
    input wire QUAD_A,
    input wire QUAD_B,
    input wire KEY_SCAN_LINE_0,
    input wire KEY_SCAN_LINE_1,
    output wire [7:0] KEY_RETURN_LINES,
    output reg KNOB_MOVED_STROBE,
    output reg ROTATION_DIRECTION_FLAG,
    output reg DIRECTION_PULSE,
    output reg EDGE_PULSE,
    output reg GATE_ACTIVE
);

    localparam ST_IDLE = 3'h1;
    localparam ST_GATE = 3'h2;
    localparam ST_STROBE = 3'h4;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [`TIMER_WIDTH-1:0] timer;
    reg [`TIMER_WIDTH-1:0] next_timer;
    reg [`SPEED_WIDTH-1:0] speed;
    reg [`SPEED_WIDTH-1:0] next_speed;
    reg [1:0] scan0_sync;
    reg [1:0] scan1_sync;
    reg [7:0] return_lines;
    wire edge_pulse;
    wire cw_pulse;
    wire cw_step;
    wire carry;
    wire gate_start;
    wire gate_done;
    wire strobe_done;
    wire scan0;
    wire scan1;
    reg [7:0] next_return_lines;

    function [7:0] one_hot3;
        input [2:0] value;
        begin
            one_hot3 = 8'h01 << value;
        end
    endfunction

    // true on the last cycle of a gate or strobe interval
    function timer_done;
        input [`TIMER_WIDTH-1:0] value;
        begin
            timer_done = (value == {`TIMER_WIDTH{1'b0}});
        end
    endfunction

    function [`TIMER_WIDTH-1:0] timer_step;
        input [`TIMER_WIDTH-1:0] value;
        begin
            timer_step = value - {{(`TIMER_WIDTH-1){1'b0}}, 1'b1};
        end
    endfunction

    // saturating add: the carry at 15 blocks the wrap back to zero
    function [`SPEED_WIDTH-1:0] speed_inc;
        input [`SPEED_WIDTH-1:0] value;
        begin
            if (value == `SPEED_MAX) begin
                speed_inc = value;
            end else begin
                speed_inc = value + 4'h1;
            end
        end
    endfunction

    function bank_match;
        input bank;
        input line0;
        input line1;
        begin
            bank_match = bank ? line1 : line0;
        end
    endfunction

    knob_edge_detect edges (
        .clk(SYS_CLK),
        .reset_n(RESET_N),
        .quad_a(QUAD_A),
        .quad_b(QUAD_B),
        .edge_pulse(edge_pulse),
        .cw_pulse(cw_pulse),
        .cw_step(cw_step)
    );

    assign carry = (speed == `SPEED_MAX);
    assign gate_start = (state == ST_IDLE) && edge_pulse;
    assign gate_done = timer_done(timer) && (state == ST_GATE);
    assign strobe_done = timer_done(timer) && (state == ST_STROBE);
    // only the second flop of each scan synchroniser is read
    assign scan0 = scan0_sync[1];
    assign scan1 = scan1_sync[1];
    assign KEY_RETURN_LINES = return_lines;

    always @* begin
        next_state = state;
        next_timer = timer;
        case (state)
            ST_IDLE: begin
                if (gate_start) begin
                    next_state = ST_GATE;
                    next_timer = `GATE_LAST;
                end
            end
            ST_GATE: begin
                if (gate_done) begin
                    next_state = ST_STROBE;
                    next_timer = `STROBE_LAST;
                end else begin
                    next_timer = timer_step(timer);
                end
            end
            ST_STROBE: begin
                if (strobe_done) begin
                    next_state = ST_IDLE;
                end else begin
                    next_timer = timer_step(timer);
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_timer = {`TIMER_WIDTH{1'b0}};
            end
        endcase
    end

    // the gate-opening edge already counts as one
    always @* begin
        next_speed = speed;
        if (gate_start) begin
            next_speed = 4'h1;
        end else if (state == ST_GATE && edge_pulse && !carry) begin
            next_speed = speed_inc(speed);
        end
    end

    // the bank bit picks the scan line, so 16 scan and return pairs are possible
    always @* begin
        next_return_lines = 8'h00;
        if (bank_match(speed[3], scan0, scan1)) begin
            next_return_lines = one_hot3(speed[2:0]);
        end
    end

    always @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            state <= ST_IDLE;
            timer <= {`TIMER_WIDTH{1'b0}};
            speed <= 4'h0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            speed <= next_speed;
        end
    end

    always @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            scan0_sync <= 2'h0;
            scan1_sync <= 2'h0;
            return_lines <= 8'h00;
        end else begin
            scan0_sync <= {scan0_sync[0], KEY_SCAN_LINE_0};
            scan1_sync <= {scan1_sync[0], KEY_SCAN_LINE_1};
            return_lines <= next_return_lines;
        end
    end

    always @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            KNOB_MOVED_STROBE <= 1'b0;
            GATE_ACTIVE <= 1'b0;
            EDGE_PULSE <= 1'b0;
            DIRECTION_PULSE <= 1'b0;
            ROTATION_DIRECTION_FLAG <= 1'b0;
        end else begin
            KNOB_MOVED_STROBE <= (next_state == ST_STROBE);
            GATE_ACTIVE <= (next_state == ST_GATE);
            EDGE_PULSE <= edge_pulse;
            DIRECTION_PULSE <= cw_pulse;
            // the flag follows every edge, also outside a gate
            if (edge_pulse) begin
                ROTATION_DIRECTION_FLAG <= cw_step;
            end
        end
    end

endmodule

/* File: verilog/spin_knob_defines.vh */
/*
 * Constants for the spin knob speed encoder: timing in milliseconds and
 * the derived cycle counts at the 40 MHz system clock.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SPIN_KNOB_DEFINES_VH
`define SPIN_KNOB_DEFINES_VH

`define CLK_KHZ 40000
`define GATE_TIME_MS 100
`define GATE_CYCLES (`GATE_TIME_MS * `CLK_KHZ)
`define STROBE_TIME_MS 20
`define STROBE_CYCLES (`STROBE_TIME_MS * `CLK_KHZ)
// first timer value of each interval, sized to the timer: gate 4000000 - 1, strobe 800000 - 1
`define GATE_LAST 23'h3d08ff
`define STROBE_LAST 23'h0c34ff
`define TIMER_WIDTH 23
`define SPEED_WIDTH 4
`define SPEED_MAX 4'hf
`define RETURN_WIDTH 8

`endif

/* File: verilog/knob_edge_detect.v */
/*
 * Quadrature front end: synchronises both square waves, emits one pulse per
 * edge of either wave and decodes the sense of rotation.
 * Assumes the knob square waves are asynchronous to the system clock.
 */
`timescale 1ns/100ps

module knob_edge_detect (
    input wire clk,
    input wire reset_n,
    input wire quad_a,
    input wire quad_b,
    output reg edge_pulse,
    output reg cw_pulse,
    output reg cw_step
);

    reg [1:0] sync_a;
    reg [1:0] sync_b;
    reg last_a;
    reg last_b;
    wire a_edge;
    wire b_edge;
    wire next_cw;

    assign a_edge = sync_a[1] ^ last_a;
    assign b_edge = sync_b[1] ^ last_b;
    // wave a leading b by a quarter cycle counts as clockwise
    assign next_cw = a_edge ? (sync_a[1] != sync_b[1]) : (sync_a[1] == sync_b[1]);

    always @(posedge clk) begin
        if (!reset_n) begin
            sync_a <= 2'h0;
            sync_b <= 2'h0;
            last_a <= 1'b0;
            last_b <= 1'b0;
            edge_pulse <= 1'b0;
            cw_pulse <= 1'b0;
            cw_step <= 1'b0;
        end else begin
            sync_a <= {sync_a[0], quad_a};
            sync_b <= {sync_b[0], quad_b};
            last_a <= sync_a[1];
            last_b <= sync_b[1];
            edge_pulse <= a_edge | b_edge;
            cw_pulse <= (a_edge | b_edge) & next_cw;
            cw_step <= next_cw;
        end
    end

endmodule

/* File: tb/knob_asserts.sv */
/* knob encoder checker; assumes it is bound to the top module. */
`timescale 1ns/100ps
module knob_asserts (
    input wire SYS_CLK,
    input wire RESET_N,
    input wire QUAD_A,
    input wire QUAD_B,
    input wire [7:0] KEY_RETURN_LINES,
    input wire DIRECTION_PULSE,
    input wire EDGE_PULSE,
    input wire GATE_ACTIVE,
    input wire KNOB_MOVED_STROBE
);
default clocking @(posedge SYS_CLK); endclocking
default disable iff (!RESET_N);
edge_seen_a: assert property ($changed(QUAD_A) || $changed(QUAD_B) |-> ##[3:5] EDGE_PULSE)
    else $error("edge lost");
pulse_one_a: assert property (EDGE_PULSE |=> !EDGE_PULSE) else $error("wide");
cw_pulse_a: assert property ($rose(QUAD_A) && !QUAD_B |-> ##[3:5] DIRECTION_PULSE)
    else $error("cw lost");
ccw_quiet_a: assert property ($rose(QUAD_A) && QUAD_B
    |-> ##[3:5] EDGE_PULSE && !DIRECTION_PULSE) else $error("ccw pulse");
dir_subset_a: assert property (DIRECTION_PULSE |-> EDGE_PULSE) else $error("stray");
gate_open_a: assert property ($rose(GATE_ACTIVE) |-> EDGE_PULSE) else $error("cause");
gate_hold_a: assert property ($rose(GATE_ACTIVE) |=> GATE_ACTIVE[*8]) else $error("gate");
ret_onehot_a: assert property ($onehot0(KEY_RETURN_LINES)) else $error("multi");
gate_strobe_a: assert property (!(GATE_ACTIVE && KNOB_MOVED_STROBE)) else $error("overlap");
strobe_after_a: assert property ($rose(KNOB_MOVED_STROBE) |-> $fell(GATE_ACTIVE))
    else $error("strobe cause");
cover property (DIRECTION_PULSE);
cover property ($rose(GATE_ACTIVE));
cover property (|KEY_RETURN_LINES);
endmodule
bind spin_knob_speed_encoder knob_asserts u_a (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
    .QUAD_A(QUAD_A), .QUAD_B(QUAD_B), .KEY_RETURN_LINES(KEY_RETURN_LINES),
    .DIRECTION_PULSE(DIRECTION_PULSE), .EDGE_PULSE(EDGE_PULSE), .GATE_ACTIVE(GATE_ACTIVE),
    .KNOB_MOVED_STROBE(KNOB_MOVED_STROBE));

/* File: tb/knob_scan_model.sv */
/* scan model, gaps between lines let returns clear; assumes they settle in 8 clocks. */
`timescale 1ns/100ps
module knob_scan_model (
    input wire clk,
    input wire [7:0] ret,
    output reg scan0 = 1'b0,
    output reg scan1 = 1'b0,
    output reg [8:0] key = 9'h000
);
reg [4:0] t = 5'h00;
always @(negedge clk) begin
    t <= t + 5'h01;
    scan0 <= t[4:3] == 2'h0;
    scan1 <= t[4:3] == 2'h2;
    if (&t[2:0] && |ret)
        key <= {scan1, ret};
end
endmodule

/* File: tb/spin_knob_speed_encoder_bench.sv */
/* knob bench, all turns inside one gate; assumes the scan model drives scan lines. */
`timescale 1ns/100ps
module spin_knob_speed_encoder_bench;
reg clk = 1'b0, rst_n = 1'b0;
reg [1:0] ph = 2'h0;
wire s0, s1, fl, stb, dp, ep, ga;
wire [7:0] rl;
wire [8:0] key;
integer fail_count = 0, cmp_count = 0;
initial forever #12.5 clk = ~clk;
spin_knob_speed_encoder u_dut (.SYS_CLK(clk), .RESET_N(rst_n), .QUAD_A(ph[0] ^ ph[1]),
    .QUAD_B(ph[1]), .KEY_SCAN_LINE_0(s0), .KEY_SCAN_LINE_1(s1), .KEY_RETURN_LINES(rl),
    .KNOB_MOVED_STROBE(stb), .ROTATION_DIRECTION_FLAG(fl), .DIRECTION_PULSE(dp),
    .EDGE_PULSE(ep), .GATE_ACTIVE(ga));
knob_scan_model u_scan (.clk(clk), .ret(rl), .scan0(s0), .scan1(s1), .key(key));
task chk(input [31:0] nm, input [8:0] e, g);
    cmp_count = cmp_count + 1;
    if (g !== e) fail_count = fail_count + 1;
    if (g !== e) $display("[FAIL] %0s exp %h got %h", nm, e, g);
endtask
task turn(input cw, input integer n, input [8:0] k);
    integer i, ne, nd;
    begin
        ne = 0;
        nd = 0;
        for (i = 0; i < 8 * n; i = i + 1) begin
            if (i % 8 == 0) ph = cw ? ph + 2'h1 : ph - 2'h1;
            @(negedge clk);
            if (ep === 1'b1) ne = ne + 1;
            if (dp === 1'b1) nd = nd + 1;
        end
    end
    chk("edgs", n[8:0], ne[8:0]);
    chk("dirp", cw ? n[8:0] : 9'h000, nd[8:0]);
    chk("flag", {8'h00, cw}, {8'h00, fl});
    chk("gate", 9'h001, {8'h00, ga});
    chk("strb", 9'h000, {8'h00, stb});
    repeat (40) @(negedge clk);
    chk("key", k, key);
endtask
task t_cw; turn(1'b1, 4, 9'h010); endtask
task t_ccw; turn(1'b0, 4, 9'h101); endtask
task t_sat; turn(1'b0, 12, 9'h180); endtask
task report_and_stop;
    $display("cmp %0d fail %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_cw;
    t_ccw;
    t_sat;
    report_and_stop;
end
endmodule
